/* lhp_pkg.sv */
// =====================================================
// Shared constants for the LCD host port
package lhp_pkg;
    // Memory sizes
    localparam int LHP_DISP_DEPTH = 80;
    localparam int LHP_GLYPH_DEPTH = 64;
    localparam int LHP_ICON_DEPTH = 16;
    localparam int LHP_FIFO_DEPTH = 4;
    localparam int LHP_ENTRY_W = 17;
    // Busy time of an instruction, in clock cycles
    localparam int LHP_INSTR_CYCLES = 8;
    // Serial start byte layout
    localparam logic [4:0] LHP_SYNC = 5'h1F;
    localparam int LHP_SB_RW = 2;
    localparam int LHP_SB_RS = 1;
    // Instruction codes and masks
    localparam logic [7:0] LHP_OPC_DISP = 8'h80;
    localparam logic [7:0] LHP_MSK_DISP = 8'h80;
    localparam logic [7:0] LHP_OPC_GLYPH = 8'h40;
    localparam logic [7:0] LHP_MSK_GLYPH = 8'hC0;
    localparam logic [7:0] LHP_OPC_ICON = 8'h10;
    localparam logic [7:0] LHP_MSK_ICON = 8'hF0;
    localparam logic [7:0] LHP_OPC_FUNC = 8'h20;
    localparam logic [7:0] LHP_MSK_FUNC = 8'hE0;
    localparam logic [7:0] LHP_OPC_ENTRY = 8'h04;
    localparam logic [7:0] LHP_MSK_ENTRY = 8'hFC;
    // Instruction field positions
    localparam int LHP_FS_DL = 4;
    localparam int LHP_FS_N = 3;
    localparam int LHP_FS_F6 = 2;
    localparam int LHP_FS_NW = 0;
    localparam int LHP_EM_ID = 1;
    // Display address layout
    localparam logic [6:0] LHP_LAST_1L = 7'h4F;
    localparam logic [6:0] LHP_L1_LAST = 7'h27;
    localparam logic [6:0] LHP_L2_BASE = 7'h40;
    localparam logic [6:0] LHP_L2_LAST = 7'h67;
    localparam logic [5:0] LHP_SPLIT_5DOT = 6'h0C;
    localparam logic [5:0] LHP_SPLIT_6DOT = 6'h0A;
    localparam logic [3:0] LHP_GLYPH_CODE_HI = 4'h0;
    // Common rows and icon segment counts
    localparam logic [5:0] LHP_COM_FIRST = 6'h01;
    localparam logic [5:0] LHP_COM_HALF = 6'h08;
    localparam logic [5:0] LHP_ICON_COM_A = 6'h00;
    localparam logic [5:0] LHP_ICON_COM_1L = 6'h11;
    localparam logic [5:0] LHP_ICON_COM_NL = 6'h21;
    localparam logic [6:0] LHP_SEG_BASE = 7'h3C;
    localparam logic [6:0] LHP_SEG_EXT = 7'h50;
    // Reset values
    localparam logic LHP_RST_DL = 1'b1;
    localparam logic LHP_RST_ID = 1'b1;
    typedef enum logic [1:0] {
        LHP_MEM_DISP, LHP_MEM_GLYPH, LHP_MEM_ICON
    } lhp_mem_t;
    typedef enum logic [1:0] {
        LHP_LINES_1, LHP_LINES_2, LHP_LINES_4
    } lhp_lines_t;
    typedef enum logic {LHP_SER_START, LHP_SER_DATA} lhp_ser_t;
endpackage

/* lhp_host_port.sv */
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// Notes on behaviour
// - Serial by mode pin, bus width by bit
// - Instruction write-only, data register read/write
// - Data writes go to selected memory
// - Address instruction prefetches addressed byte
// - Data read reloads register from next address
// - Select from pin or start byte bit
// - Busy refuses further instructions
// - Status read gives busy and pointer
// - Select and direction decode access kind
// - Address instruction loads pointer, picks memory
// - Pointer steps after each data access
// - Eighty display bytes, all host usable
// - Line mode from two bits
// - Two-line 5-dot halves at 0C, 4C
// - Two-line 6-dot halves at 0A, 4A
// - Four lines of eight rows each
// - Icon rows by line mode, segment count by extension pin
// - Icon byte: six on, two blink
// - Low codes select eight glyph RAM patterns
// - Refresh and host access in separate slots

// =====================================================
// Small FIFO between host writes and memory
module lhp_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("lhp_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire logic push;
    wire logic pop;

    // Handshakes; full and empty come from the count
    assign in_ready_o = (cnt_q != FULL);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Storage needs no reset; the count guards it
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers wrap at DEPTH, not at a power of two
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // lhp_fifo

// =====================================================
// Host port, memories and refresh read-out
module lhp_host_port import lhp_pkg::*; #(
    parameter int INSTR_CYCLES = LHP_INSTR_CYCLES,
    parameter int FIFO_DEPTH = LHP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Straps
    input wire logic interface_mode_pin_i,
    input wire logic extension_enable_pin_i,
    // Parallel bus; enable_i is also the serial clock
    input wire logic enable_i,
    input wire logic register_select_i,
    input wire logic read_not_write_i,
    input wire logic [7:0] db_i,
    output logic [7:0] db_o,
    output logic db_oe_n_o,
    // Serial link
    input wire logic serial_select_n_i,
    input wire logic serial_data_i,
    output logic serial_data_o,
    // Status
    output logic busy_indication_o,
    // Refresh read-out
    output logic [6:0] refresh_addr_o,
    output logic [7:0] refresh_code_o,
    output logic [1:0] refresh_line_o,
    output logic [5:0] refresh_com_o,
    output logic refresh_glyph_ram_o,
    output logic [5:0] icon_on_o,
    output logic [1:0] icon_blink_o,
    output logic [5:0] icon_com_a_o,
    output logic [5:0] icon_com_b_o,
    output logic [6:0] icon_seg_count_o
);
    localparam int CW = $clog2(INSTR_CYCLES + 1);
    localparam logic [CW-1:0] BUSY_LOAD = CW'(INSTR_CYCLES);
    localparam logic [6:0] DISP_LAST = 7'(LHP_DISP_DEPTH - 1);

    if (INSTR_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_chk
        $error("lhp_host_port needs INSTR_CYCLES>=1, FIFO_DEPTH>=2");
    end

    // =================================================
    // Helper functions
    function automatic logic op_is(input logic [7:0] b,
        input logic [7:0] code, input logic [7:0] mask);
        return (b & mask) == code;
    endfunction

    // Next pointer value; display wraps per line layout
    function automatic logic [6:0] step_addr(input logic [6:0] a,
        input lhp_mem_t m, input lhp_lines_t l, input logic inc);
        logic [6:0] n;
        n = inc ? a + 7'h01 : a - 7'h01;
        case (m)
            LHP_MEM_GLYPH: n = {1'b0, n[5:0]};
            LHP_MEM_ICON: n = {3'h0, n[3:0]};
            default: begin
                if (l == LHP_LINES_1) begin
                    if (inc && a == LHP_LAST_1L) n = 7'h00;
                    else if (!inc && a == 7'h00) n = LHP_LAST_1L;
                end else begin
                    if (inc && a == LHP_L1_LAST) n = LHP_L2_BASE;
                    else if (inc && a == LHP_L2_LAST) n = 7'h00;
                    else if (!inc && a == 7'h00) n = LHP_L2_LAST;
                    else if (!inc && a == LHP_L2_BASE) n = LHP_L1_LAST;
                end
            end
        endcase
        return n;
    endfunction

    // Text line of a display address
    function automatic logic [1:0] line_of(input logic [6:0] a,
        input lhp_lines_t l);
        case (l)
            LHP_LINES_2: return {1'b0, a[6]};
            LHP_LINES_4: return a[6:5];
            default: return 2'h0;
        endcase
    endfunction

    // First common row driven by a display address
    function automatic logic [5:0] com_of(input logic [6:0] a,
        input lhp_lines_t l, input logic f6);
        logic [5:0] split;
        logic half;
        split = f6 ? LHP_SPLIT_6DOT : LHP_SPLIT_5DOT;
        half = (l == LHP_LINES_1) ? (a >= {1'b0, split})
                                  : (a[5:0] >= split);
        case (l)
            LHP_LINES_4: return {1'b0, a[6:5], 3'h0} + LHP_COM_FIRST;
            LHP_LINES_2: return {1'b0, a[6], 4'h0} + LHP_COM_FIRST
                + (half ? LHP_COM_HALF : 6'h00);
            default: return LHP_COM_FIRST
                + (half ? LHP_COM_HALF : 6'h00);
        endcase
    endfunction

    // =================================================
    // State
    logic bus_width_q, two_line_q, four_line_q, font6_q, inc_q;
    lhp_mem_t target_q;
    logic [6:0] ptr_q;
    logic [7:0] dtr_q;
    logic [CW-1:0] instr_cnt_q;
    logic pend_q, busy_q, slot_q, e_prev_q, nib_q;
    logic [3:0] hi_q;
    lhp_ser_t ser_state_q;
    logic [2:0] ser_cnt_q;
    logic [7:0] ser_sh_q, ser_out_q;
    logic ser_rs_q, ser_rw_q, sod_q;
    logic [7:0] db_q;
    logic db_oe_n_q;
    logic [6:0] scan_q;
    logic [7:0] disp_mem [LHP_DISP_DEPTH];
    logic [7:0] glyph_mem [LHP_GLYPH_DEPTH];
    logic [7:0] icon_mem [LHP_ICON_DEPTH];

    // =================================================
    // Strobe edges and access capture
    wire logic par_mode, e_rise, e_fall, ser_rise, ser_fall;
    wire logic par_ev, ser_ev, acc_v, acc_rs, acc_rw;
    wire logic [7:0] par_byte, ser_byte, acc_byte, rd_value;
    wire logic ser_rs_nxt, sel_rs;
    lhp_lines_t lines;

    assign par_mode = ~interface_mode_pin_i;
    assign e_rise = enable_i & ~e_prev_q;
    assign e_fall = ~enable_i & e_prev_q;
    assign ser_rise = ~par_mode & ~serial_select_n_i & e_rise;
    assign ser_fall = ~par_mode & ~serial_select_n_i & e_fall;
    // 4-bit bus: high nibble first, the pair acts as one access
    assign par_ev = par_mode & e_fall & (bus_width_q | nib_q);
    assign par_byte = bus_width_q ? db_i : {hi_q, db_i[7:4]};
    assign ser_byte = {ser_sh_q[6:0], serial_data_i};
    assign ser_ev = ser_rise & (ser_state_q == LHP_SER_DATA)
        & (ser_cnt_q == 3'h7);
    assign acc_v = par_ev | ser_ev;
    assign acc_rs = par_mode ? register_select_i : ser_rs_q;
    assign acc_rw = par_mode ? read_not_write_i : ser_rw_q;
    assign acc_byte = par_mode ? par_byte : ser_byte;
    assign ser_rs_nxt = (ser_state_q == LHP_SER_START)
        ? ser_byte[LHP_SB_RS] : ser_rs_q;
    assign sel_rs = par_mode ? register_select_i : ser_rs_nxt;
    // Instruction register never reads back; status does
    assign rd_value = sel_rs ? dtr_q : {busy_q, ptr_q};
    // Line mode from the two bits, four-line wins
    assign lines = four_line_q ? LHP_LINES_4
        : (two_line_q ? LHP_LINES_2 : LHP_LINES_1);

    // =================================================
    // Access decode and instruction fields
    wire logic wr_instr, wr_data, rd_data, fifo_in_ready;
    wire logic op_disp, op_glyph, op_icon, op_func, op_entry;
    wire logic set_addr, prefetch, pop, f_valid;
    wire logic [6:0] new_ptr, ptr_next, f_addr;
    wire logic [7:0] f_data, host_rd;
    wire logic [LHP_ENTRY_W-1:0] f_out;
    lhp_mem_t new_tgt, f_tgt;

    assign wr_instr = acc_v & ~acc_rs & ~acc_rw & ~busy_q;
    assign wr_data = acc_v & acc_rs & ~acc_rw & fifo_in_ready;
    assign rd_data = acc_v & acc_rs & acc_rw;
    assign op_disp = wr_instr & op_is(acc_byte, LHP_OPC_DISP,
        LHP_MSK_DISP);
    assign op_glyph = wr_instr & op_is(acc_byte, LHP_OPC_GLYPH,
        LHP_MSK_GLYPH);
    assign op_icon = wr_instr & op_is(acc_byte, LHP_OPC_ICON,
        LHP_MSK_ICON);
    assign op_func = wr_instr & op_is(acc_byte, LHP_OPC_FUNC,
        LHP_MSK_FUNC);
    assign op_entry = wr_instr & op_is(acc_byte, LHP_OPC_ENTRY,
        LHP_MSK_ENTRY);
    assign set_addr = op_disp | op_glyph | op_icon;
    // Address field width follows the named memory
    assign new_ptr = op_disp ? acc_byte[6:0]
        : (op_glyph ? {1'b0, acc_byte[5:0]}
                    : {3'h0, acc_byte[3:0]});
    assign new_tgt = op_disp ? LHP_MEM_DISP
        : (op_glyph ? LHP_MEM_GLYPH : LHP_MEM_ICON);
    assign ptr_next = step_addr(ptr_q, target_q, lines, inc_q);

    // Host memory work only in host slots, refresh never waits
    assign pop = f_valid & slot_q & (instr_cnt_q == '0);
    assign prefetch = pend_q & slot_q & ~f_valid
        & (instr_cnt_q == '0);
    assign f_tgt = lhp_mem_t'(f_out[16:15]);
    assign f_addr = f_out[14:8];
    assign f_data = f_out[7:0];
    assign host_rd = (target_q == LHP_MEM_GLYPH)
        ? glyph_mem[ptr_q[5:0]]
        : ((target_q == LHP_MEM_ICON) ? icon_mem[ptr_q[3:0]]
        : ((ptr_q <= DISP_LAST) ? disp_mem[ptr_q] : 8'h00));

    // Each write carries its own target and address
    lhp_fifo #(
        .WIDTH(LHP_ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(acc_v & acc_rs & ~acc_rw),
        .in_ready_o(fifo_in_ready),
        .in_data_i({target_q, ptr_q, acc_byte}),
        .out_valid_o(f_valid),
        .out_ready_i(pop),
        .out_data_o(f_out)
    );

    // =================================================
    // Memory writes; out-of-range display addresses drop
    always_ff @(posedge clock_i) begin
        if (pop) begin
            case (f_tgt)
                LHP_MEM_GLYPH: glyph_mem[f_addr[5:0]] <= f_data;
                LHP_MEM_ICON: icon_mem[f_addr[3:0]] <= f_data;
                default: begin
                    if (f_addr <= DISP_LAST) begin
                        disp_mem[f_addr] <= f_data;
                    end
                end
            endcase
        end
    end

    // Modes, pointer and data register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_width_q <= LHP_RST_DL;
            two_line_q <= 1'b0;
            four_line_q <= 1'b0;
            font6_q <= 1'b0;
            inc_q <= LHP_RST_ID;
            target_q <= LHP_MEM_DISP;
            ptr_q <= 7'h00;
            dtr_q <= 8'h00;
        end else begin
            if (op_func) begin
                bus_width_q <= acc_byte[LHP_FS_DL];
                two_line_q <= acc_byte[LHP_FS_N];
                font6_q <= acc_byte[LHP_FS_F6];
                four_line_q <= acc_byte[LHP_FS_NW];
            end
            if (op_entry) begin
                inc_q <= acc_byte[LHP_EM_ID];
            end
            if (set_addr) begin
                ptr_q <= new_ptr;
                target_q <= new_tgt;
            end else if (wr_data || rd_data) begin
                ptr_q <= ptr_next;
            end
            if (wr_data) begin
                dtr_q <= acc_byte;
            end else if (prefetch) begin
                dtr_q <= host_rd;
            end
        end
    end

    // Busy: counter for instructions, queue for data
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            instr_cnt_q <= '0;
            pend_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (wr_instr) begin
                instr_cnt_q <= BUSY_LOAD;
            end else if (instr_cnt_q != '0) begin
                instr_cnt_q <= instr_cnt_q - 1'b1;
            end
            // A new request wins over the prefetch finishing
            pend_q <= set_addr | rd_data | (pend_q & ~prefetch);
            busy_q <= wr_instr | wr_data | (instr_cnt_q > 1)
                | (f_valid & ~pop) | (pend_q & ~prefetch)
                | set_addr | rd_data;
        end
    end

    // =================================================
    // Parallel bus: nibble pairing and read drive
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            e_prev_q <= 1'b0;
            nib_q <= 1'b0;
            hi_q <= 4'h0;
            db_q <= 8'h00;
            db_oe_n_q <= 1'b1;
        end else begin
            e_prev_q <= enable_i;
            // Width change restarts pairing at the high nibble
            if (op_func) begin
                nib_q <= 1'b0;
            end else if (par_mode && e_fall && !bus_width_q) begin
                nib_q <= ~nib_q;
                if (!nib_q) begin
                    hi_q <= db_i[7:4];
                end
            end
            db_q <= bus_width_q ? rd_value
                : (nib_q ? {rd_value[3:0], 4'h0}
                         : {rd_value[7:4], 4'h0});
            db_oe_n_q <= ~(par_mode & enable_i & read_not_write_i);
        end
    end

    // =================================================
    // Serial link: start byte, then bytes MSB first
    // Back-to-back reads reuse the byte seen at the last
    // byte boundary, so a prefetch may not be visible yet.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ser_state_q <= LHP_SER_START;
            ser_cnt_q <= 3'h0;
            ser_sh_q <= 8'h00;
            ser_rs_q <= 1'b0;
            ser_rw_q <= 1'b0;
            ser_out_q <= 8'h00;
            sod_q <= 1'b0;
        end else if (serial_select_n_i || par_mode) begin
            ser_state_q <= LHP_SER_START;
            ser_cnt_q <= 3'h0;
        end else if (ser_rise) begin
            ser_sh_q <= ser_byte;
            ser_cnt_q <= ser_cnt_q + 3'h1;
            if (ser_cnt_q == 3'h7) begin
                ser_out_q <= rd_value;
                case (ser_state_q)
                    LHP_SER_START: begin
                        if (ser_byte[7:3] == LHP_SYNC) begin
                            ser_state_q <= LHP_SER_DATA;
                            ser_rw_q <= ser_byte[LHP_SB_RW];
                            ser_rs_q <= ser_byte[LHP_SB_RS];
                        end
                    end
                    default: ;
                endcase
            end
        end else if (ser_fall && ser_state_q == LHP_SER_DATA
                     && ser_rw_q) begin
            sod_q <= ser_out_q[7];
            ser_out_q <= {ser_out_q[6:0], 1'b0};
        end
    end

    // =================================================
    // Refresh slots: display and icon scan read-out
    wire logic [7:0] scan_code, icon_word;
    assign scan_code = disp_mem[scan_q];
    assign icon_word = icon_mem[scan_q[3:0]];

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            slot_q <= 1'b0;
            scan_q <= 7'h00;
            refresh_addr_o <= 7'h00;
            refresh_code_o <= 8'h00;
            refresh_line_o <= 2'h0;
            refresh_com_o <= LHP_COM_FIRST;
            refresh_glyph_ram_o <= 1'b0;
            icon_on_o <= 6'h00;
            icon_blink_o <= 2'h0;
            icon_com_a_o <= LHP_ICON_COM_A;
            icon_com_b_o <= LHP_ICON_COM_1L;
            icon_seg_count_o <= LHP_SEG_BASE;
        end else begin
            slot_q <= ~slot_q;
            icon_com_a_o <= LHP_ICON_COM_A;
            icon_com_b_o <= (lines == LHP_LINES_1)
                ? LHP_ICON_COM_1L : LHP_ICON_COM_NL;
            icon_seg_count_o <= extension_enable_pin_i
                ? LHP_SEG_EXT : LHP_SEG_BASE;
            if (!slot_q) begin
                scan_q <= (scan_q == DISP_LAST) ? 7'h00
                    : scan_q + 7'h01;
                refresh_addr_o <= scan_q;
                refresh_code_o <= scan_code;
                refresh_line_o <= line_of(scan_q, lines);
                refresh_com_o <= com_of(scan_q, lines,
                    font6_q);
                refresh_glyph_ram_o <= (scan_code[7:4]
                    == LHP_GLYPH_CODE_HI);
                icon_on_o <= icon_word[5:0];
                icon_blink_o <= icon_word[7:6];
            end
        end
    end

    // Outputs straight from flops
    assign db_o = db_q;
    assign db_oe_n_o = db_oe_n_q;
    assign serial_data_o = sod_q;
    assign busy_indication_o = busy_q;
endmodule // lhp_host_port
`default_nettype wire

/* lhp_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ======
// Port checker for the host port
module lhp_checker #(
    parameter int INSTR_CYCLES = 8
) (
    // Clock, reset and host inputs
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic interface_mode_pin_i,
    input wire logic extension_enable_pin_i,
    input wire logic enable_i,
    input wire logic register_select_i,
    input wire logic read_not_write_i,
    // Watched outputs
    input wire logic db_oe_n_o,
    input wire logic busy_indication_o,
    input wire logic [6:0] refresh_addr_o,
    input wire logic [5:0] icon_com_b_o,
    input wire logic [6:0] icon_seg_count_o
);
    // Longest busy: an instruction plus a full drain and prefetch
    localparam int BUSY_MAX = INSTR_CYCLES + 16;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // Decoded host access kinds
    wire logic par_rd = enable_i && read_not_write_i && !interface_mode_pin_i;
    wire logic ins_wr = !register_select_i && !read_not_write_i &&
        !interface_mode_pin_i;
    property p_seg80; extension_enable_pin_i |=> icon_seg_count_o == 7'h50;
    endproperty
    a_seg80: assert property (p_seg80) else $error("not 80 segs");
    property p_seg60; !extension_enable_pin_i |=> icon_seg_count_o == 7'h3C;
    endproperty
    a_seg60: assert property (p_seg60) else $error("not 60 segs");
    property p_icom; icon_com_b_o == 6'h11 || icon_com_b_o == 6'h21;
    endproperty
    a_icom: assert property (p_icom) else $error("icon row wrong");
    property p_oe_on; par_rd |=> !db_oe_n_o; endproperty
    a_oe_on: assert property (p_oe_on) else $error("read not driven");
    property p_oe_off; !par_rd |=> db_oe_n_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("pins driven");
    property p_bset;
        $fell(enable_i) && ins_wr && !busy_indication_o |=>
            busy_indication_o [*8];
    endproperty
    a_bset: assert property (p_bset) else $error("busy not held");
    property p_bclr;
        $rose(busy_indication_o) |-> ##[1:BUSY_MAX] !busy_indication_o;
    endproperty
    a_bclr: assert property (p_bclr) else $error("busy stuck");
    property p_addr; refresh_addr_o < 7'h50; endproperty
    a_addr: assert property (p_addr) else $error("scan beyond 80");
endmodule // lhp_checker
bind lhp_host_port lhp_checker #(.INSTR_CYCLES(INSTR_CYCLES)) u_chk (
    .clock_i, .arst_n_i, .interface_mode_pin_i, .extension_enable_pin_i,
    .enable_i, .register_select_i, .read_not_write_i, .db_oe_n_o,
    .busy_indication_o, .refresh_addr_o, .icon_com_b_o, .icon_seg_count_o
);
`default_nettype wire

/* lhp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ======
// Host processor on the parallel bus
module lhp_host_model (
    // Clock and device side of the pins
    input wire logic clock_i,
    input wire logic [7:0] dut_db_i,
    input wire logic dut_oe_n_i,
    // Strobes and resolved data wire
    output logic enable_o,
    output logic select_o,
    output logic rnw_o,
    output logic [7:0] bus_o
);
    logic [7:0] drv_q = 8'h00;
    // Wire level: the device wins while its enable is low
    assign bus_o = dut_oe_n_i ? drv_q : dut_db_i;
    initial enable_o = 1'h0;
    initial select_o = 1'h0;
    initial rnw_o = 1'h0;
    // One access: strobe high three cycles, taken on its fall
    task automatic acc(input logic rs, input logic rw,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clock_i);
        enable_o <= 1'h1;
        select_o <= rs;
        rnw_o <= rw;
        drv_q <= rw ? ~drv_q : d;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        q = bus_o;
        @(posedge clock_i);
        enable_o <= 1'h0;
        @(posedge clock_i);
        drv_q <= ~drv_q; // Released pins never keep the old value
    endtask
    // Poll status until the busy bit clears
    task automatic idle();
        logic [7:0] s;
        s = 8'hFF;
        for (int i = 0; i < 64 && s[7] !== 1'h0; i++) begin
            acc(1'h0, 1'h1, 8'h00, s);
        end
        if (s[7] !== 1'h0) tb_lhp_host_port.n_fail++;
    endtask
    // Serial clock pulse
    task automatic pulse();
        @(posedge clock_i);
        enable_o <= 1'h1;
        @(posedge clock_i);
        enable_o <= 1'h0;
    endtask
endmodule // lhp_host_model
`default_nettype wire

/* tb_lhp_host_port.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin \
    comparisons++; \
    if ((a) !== (e)) begin \
        n_fail++; \
        $display("mismatch at %0t: %h vs %h", $time, a, e); \
    end \
end
// ======
// Bench for the host port
module tb_lhp_host_port;
    logic clock_i = 1'h0;
    logic arst_n_i = 1'h0;
    logic ext_q = 1'h0;
    logic im_q = 1'h0, sd_q = 1'h0;
    wire logic enable, select, rnw, db_oe_n_o, busy_indication_o;
    wire logic [7:0] bus, db_o;
    int n_fail = 0;
    int comparisons = 0;
    // Long busy so a second instruction lands inside it
    lhp_host_port #(.INSTR_CYCLES(20)) u_dut (
        .clock_i, .arst_n_i, .interface_mode_pin_i(im_q),
        .extension_enable_pin_i(ext_q), .enable_i(enable),
        .register_select_i(select), .read_not_write_i(rnw), .db_i(bus),
        .db_o, .db_oe_n_o, .serial_select_n_i(~im_q), .serial_data_i(sd_q),
        .serial_data_o(), .busy_indication_o, .refresh_addr_o(),
        .refresh_code_o(), .refresh_line_o(), .refresh_com_o(),
        .refresh_glyph_ram_o(), .icon_on_o(), .icon_blink_o(),
        .icon_com_a_o(), .icon_com_b_o(), .icon_seg_count_o()
    );
    lhp_host_model u_host (
        .clock_i, .dut_db_i(db_o), .dut_oe_n_i(db_oe_n_o),
        .enable_o(enable), .select_o(select), .rnw_o(rnw), .bus_o(bus)
    );
    // Clock and bus helpers
    initial forever #2.5 clock_i = ~clock_i;
    task automatic wr(input logic rs, input logic [7:0] d);
        logic [7:0] q;
        u_host.acc(rs, 1'h0, d, q);
    endtask
    task automatic rd(input logic rs, input logic [7:0] e);
        logic [7:0] q;
        u_host.acc(rs, 1'h1, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic sb(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sd_q <= b[i];
            u_host.pulse();
        end
    endtask
    task automatic ins(input logic [7:0] d);
        u_host.idle();
        wr(1'h0, d);
        u_host.idle();
    endtask
    task automatic results();
        if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog well beyond the several hundred cycles the tests need
    initial begin
        #100000;
        n_fail++;
        results();
    end
    // Test sequence
    initial begin
        repeat (3) @(posedge clock_i);
        arst_n_i <= 1'h1;
        rd(1'h0, 8'h00);
        ins(8'h85);
        rd(1'h0, 8'h05);
        wr(1'h1, 8'h41);
        wr(1'h1, 8'h42);
        u_host.idle();
        rd(1'h0, 8'h07);
        ins(8'h85);
        rd(1'h1, 8'h41);
        u_host.idle();
        rd(1'h1, 8'h42);
        ins(8'h04);
        ins(8'h86);
        rd(1'h1, 8'h42);
        u_host.idle();
        rd(1'h1, 8'h41);
        ins(8'h06);
        ins(8'hCF);
        wr(1'h1, 8'h33);
        u_host.idle();
        rd(1'h0, 8'h00);
        ins(8'hCF);
        rd(1'h1, 8'h33);
        ins(8'h48);
        wr(1'h1, 8'h1F);
        ins(8'h48);
        rd(1'h1, 8'h1F);
        ins(8'h13);
        wr(1'h1, 8'hC5);
        ins(8'h13);
        rd(1'h1, 8'hC5);
        u_host.idle();
        ext_q <= 1'h1;
        wr(1'h0, 8'hA0);
        rd(1'h0, 8'hA0);
        wr(1'h0, 8'hB0);
        u_host.idle();
        rd(1'h0, 8'h20);
        ins(8'h38);
        ins(8'hA7);
        wr(1'h1, 8'h5A);
        u_host.idle();
        rd(1'h0, 8'h40);
        im_q <= 1'h1;
        sb(8'hF8);
        sb(8'h8A);
        im_q <= 1'h0;
        u_host.idle();
        rd(1'h0, 8'h0A);
        results();
    end
endmodule // tb_lhp_host_port
`default_nettype wire
